// *** design/cmc_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmc_pin_sync #(
  parameter int W = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Three stages, change accepted once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      level_o <= '1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : cmc_pin_sync
`default_nettype wire

// *** design/cmc_soft_reset.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmc_soft_reset #(
  parameter int CYCLES = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start_i,
  output logic busy_o
);
  logic [7:0] cnt_q;

  // Internal reset cycle, bit drops by itself at the end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 8'h00;
      busy_o <= 1'b0;
    end else if (start_i) begin
      cnt_q <= 8'(CYCLES - 1);
      busy_o <= 1'b1;
    end else if (busy_o) begin
      if (cnt_q == 8'h00) begin
        busy_o <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : cmc_soft_reset
`default_nettype wire

// *** design/cmc_top.sv ***
// Overview of operation
// - Not-ready flag shows stop or debug mode
// - Wake interrupt only when wake mask set
// - Soft reset clears sequencer and host registers
// - Soft reset keeps control zero register
// - Soft reset also clears stop request
// - Soft reset bit self-clears when done
// - Freeze acknowledge while debug, prescaler off
// - Supervisor select restricts shared registers
// - Self-wake on bus edge clears stop
// - Coinciding edge leaves self-wake clear
// - Auto power save gates idle clocks
// - Stop acknowledge while clocks are halted
// - Four-bit arbitration id, distinct and nonzero; the code resets it to zero and accepts any written value
// - Level selects request line, ack compares
// - Vector base gives vector top bits
// - Uninitialized vector returned until a nonzero base write
// - Bus-off request only when masked in
// - Error request only when masked in
// - Receive polarity bits map pin levels
// - Transmit mode selects drive and polarity
// - Open drain drives dominant only, positive
// - Stop set by host, cleared by wake
// - Halt set at reset acts as freeze
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defines.svh"
module cmc_top #(
  parameter int SOFT_RESET_CYCLES = `CMC_SOFT_RESET_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hprot,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic freeze_i,
  input wire logic core_idle_i,
  input wire logic bus_off_i,
  input wire logic error_i,
  input wire logic core_tx_dominant_i,
  input wire logic iack_i,
  input wire logic [2:0] iack_level_i,
  input wire logic receive_pin_first,
  input wire logic receive_pin_second,
  output logic transmit_pin_first_o,
  output logic transmit_pin_first_oe,
  output logic transmit_pin_second_o,
  output logic transmit_pin_second_oe,
  output logic [1:0] rx_dominant_o,
  output cmc_pkg::cmc_mode_t mode_o,
  output logic prescaler_enable_o,
  output logic module_clk_en_o,
  output logic core_soft_reset_o,
  output logic [7:0] irq_lines_o,
  output logic [3:0] interrupt_arbitration_id_o,
  output logic iack_resp_o,
  output logic [7:0] iack_vector_o
);
  import cmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic ap_wr_q;
  logic ap_rd_q;
  logic ap_priv_q;
  logic [4:0] ap_addr_q;
  logic stop_q;
  logic freeze_response_enable_q;
  logic halt_q;
  logic wake_interrupt_mask_q;
  logic supervisor_space_select_q;
  logic self_wake_enable_q;
  logic auto_power_save_q;
  logic [3:0] interrupt_arbitration_id_q;
  logic [2:0] interrupt_request_level_q;
  logic [2:0] interrupt_vector_base_q;
  logic vec_init_q;
  logic bus_off_interrupt_mask_q;
  logic error_interrupt_mask_q;
  logic [1:0] receive_polarity_select_q;
  cmc_transmit_drive_select_t transmit_drive_select_q;
  logic wake_pend_q;
  cmc_mode_t mode_q;
  cmc_mode_t mode_d;
  logic [1:0] rx_level;
  logic rx_prev_q;
  logic rx_edge;
  logic soft_reset_request;
  logic soft_start;
  logic wr_en;
  logic wr_modcfg;
  logic wr_intcfg;
  logic wr_ctrl;
  logic wr_status;
  logic wake_hit;
  logic freeze_want;
  logic not_ready_flag;
  logic freeze_acknowledge;
  logic stop_acknowledge;
  logic src_boff;
  logic src_err;
  logic src_wake;
  logic irq_any;
  logic iack_hit;
  logic tx_dom;

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic acc_ok(input logic [4:0] a, input logic priv, input logic sup);
    acc_ok = priv || (!sup && (a == `CMC_OFS_CTRLZERO || a == `CMC_OFS_STATUS));
  endfunction : acc_ok

  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  cmc_pin_sync #(.W(2)) cmc_pin_sync_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_i({receive_pin_second, receive_pin_first}),
    .level_o(rx_level)
  );

  cmc_soft_reset #(.CYCLES(SOFT_RESET_CYCLES)) cmc_soft_reset_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .start_i(soft_start),
    .busy_o(soft_reset_request)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_priv_q <= 1'b0;
      ap_addr_q <= 5'h00;
    end else if (hready) begin
      ap_wr_q <= hsel && htrans[1] && hwrite;
      ap_rd_q <= hsel && htrans[1] && !hwrite;
      ap_priv_q <= hprot[1];
      ap_addr_q <= (haddr[31:5] == 27'h000_0000) ? haddr[4:0] : 5'h1F;
    end
  end

  assign wr_en = ap_wr_q && acc_ok(ap_addr_q, ap_priv_q, supervisor_space_select_q);
  assign wr_modcfg = wr_en && hit(ap_addr_q, `CMC_OFS_MODCFG) && !soft_reset_request;
  assign wr_intcfg = wr_en && hit(ap_addr_q, `CMC_OFS_INTCFG);
  assign wr_ctrl = wr_en && hit(ap_addr_q, `CMC_OFS_CTRLZERO);
  assign wr_status = wr_en && hit(ap_addr_q, `CMC_OFS_STATUS);
  assign soft_start = wr_modcfg && hwdata[`CMC_MC_SOFTRESET];

  // Read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= 32'h0000_0000;
      if (acc_ok(haddr[4:0], hprot[1], supervisor_space_select_q) && haddr[31:5] == 27'h0) begin
        case (haddr[4:0])
          `CMC_OFS_MODCFG: begin
            hrdata[15:0] <= {stop_q, freeze_response_enable_q, 1'b0, halt_q, not_ready_flag,
              wake_interrupt_mask_q, soft_reset_request, freeze_acknowledge,
              supervisor_space_select_q, self_wake_enable_q, auto_power_save_q,
              stop_acknowledge, interrupt_arbitration_id_q};
          end
          `CMC_OFS_INTCFG: begin
            hrdata[`CMC_IC_LVL_HI:`CMC_IC_LVL_LO] <= interrupt_request_level_q;
            hrdata[`CMC_IC_VEC_HI:`CMC_IC_VEC_LO] <= interrupt_vector_base_q;
          end
          `CMC_OFS_CTRLZERO: begin
            hrdata[7:0] <= {bus_off_interrupt_mask_q, error_interrupt_mask_q, 2'b00,
              receive_polarity_select_q, transmit_drive_select_q};
          end
          `CMC_OFS_STATUS: begin
            hrdata[2:0] <= {error_i, bus_off_i, wake_pend_q};
          end
          default: begin
            hrdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Module configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_q <= 1'b0;
      freeze_response_enable_q <= `CMC_RST_FRZEN;
      halt_q <= `CMC_RST_HALT;
      wake_interrupt_mask_q <= 1'b0;
      supervisor_space_select_q <= `CMC_RST_SUPER;
      self_wake_enable_q <= 1'b0;
      auto_power_save_q <= 1'b0;
      interrupt_arbitration_id_q <= `CMC_RST_ARB;
    end else if (soft_start) begin
      stop_q <= 1'b0;
      freeze_response_enable_q <= `CMC_RST_FRZEN;
      halt_q <= `CMC_RST_HALT;
      wake_interrupt_mask_q <= 1'b0;
      supervisor_space_select_q <= `CMC_RST_SUPER;
      self_wake_enable_q <= 1'b0;
      auto_power_save_q <= 1'b0;
      interrupt_arbitration_id_q <= `CMC_RST_ARB;
    end else begin
      if (wr_modcfg) begin
        // Status flags in this word are not stored
        stop_q <= hwdata[`CMC_MC_STOP] && !(hwdata[`CMC_MC_SELF_WAKE_ENABLE] && rx_edge);
        freeze_response_enable_q <= hwdata[`CMC_MC_FRZEN];
        halt_q <= hwdata[`CMC_MC_HALT];
        wake_interrupt_mask_q <= hwdata[`CMC_MC_WAKEMASK];
        supervisor_space_select_q <= hwdata[`CMC_MC_SUPER];
        self_wake_enable_q <= hwdata[`CMC_MC_SELF_WAKE_ENABLE] && !rx_edge;
        auto_power_save_q <= hwdata[`CMC_MC_AUTOPS];
        interrupt_arbitration_id_q <= hwdata[`CMC_MC_ARB_HI:0];
      end
      if (wake_hit) begin
        stop_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt configuration, control zero and wake flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_request_level_q <= `CMC_RST_LVL;
      interrupt_vector_base_q <= `CMC_RST_VEC;
      vec_init_q <= 1'b0;
    end else if (soft_start) begin
      interrupt_request_level_q <= `CMC_RST_LVL;
      interrupt_vector_base_q <= `CMC_RST_VEC;
      vec_init_q <= 1'b0;
    end else if (wr_intcfg) begin
      interrupt_request_level_q <= hwdata[`CMC_IC_LVL_HI:`CMC_IC_LVL_LO];
      interrupt_vector_base_q <= hwdata[`CMC_IC_VEC_HI:`CMC_IC_VEC_LO];
      // A base left at zero counts as not yet programmed
      vec_init_q <= vec_init_q || (hwdata[`CMC_IC_VEC_HI:`CMC_IC_VEC_LO] != `CMC_RST_VEC);
    end
  end

  // Not touched by soft reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {bus_off_interrupt_mask_q, error_interrupt_mask_q, receive_polarity_select_q,
        transmit_drive_select_q} <= 6'h00;
    end else if (wr_ctrl) begin
      bus_off_interrupt_mask_q <= hwdata[`CMC_C0_BOFFMASK];
      error_interrupt_mask_q <= hwdata[`CMC_C0_ERRMASK];
      receive_polarity_select_q <= hwdata[`CMC_C0_RX_HI:`CMC_C0_RX_LO];
      transmit_drive_select_q <= hwdata[`CMC_C0_TX_HI:`CMC_C0_TX_LO];
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_pend_q <= 1'b0;
    end else if (wake_hit) begin
      wake_pend_q <= 1'b1;
    end else if (soft_start || (wr_status && hwdata[`CMC_ST_WAKE])) begin
      wake_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  assign freeze_want = freeze_response_enable_q && (freeze_i || halt_q);
  assign wake_hit = (mode_q == CMC_STOP) && self_wake_enable_q && rx_edge;

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      CMC_RUN: begin
        if (stop_q) begin
          mode_d = CMC_STOP;
        end else if (freeze_want) begin
          mode_d = CMC_FREEZE;
        end
      end
      CMC_FREEZE: begin
        if (!freeze_want) begin
          mode_d = CMC_RUN;
        end
      end
      CMC_STOP: begin
        if (!stop_q) begin
          mode_d = CMC_RUN;
        end
      end
      default: begin
        mode_d = CMC_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= CMC_RUN;
    end else if (soft_start) begin
      mode_q <= CMC_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign not_ready_flag = (mode_q != CMC_RUN);
  assign freeze_acknowledge = (mode_q == CMC_FREEZE);
  assign stop_acknowledge = (mode_q == CMC_STOP);
  assign mode_o = mode_q;
  assign prescaler_enable_o = (mode_q == CMC_RUN);
  assign core_soft_reset_o = soft_reset_request;
  assign interrupt_arbitration_id_o = interrupt_arbitration_id_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_clk_en_o <= 1'b1;
    end else begin
      module_clk_en_o <= !stop_q && !(auto_power_save_q && core_idle_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request and acknowledge
  assign src_boff = bus_off_i && bus_off_interrupt_mask_q;
  assign src_err = error_i && error_interrupt_mask_q;
  assign src_wake = wake_pend_q && wake_interrupt_mask_q;
  assign irq_any = src_boff || src_err || src_wake;
  assign iack_hit = iack_i && irq_any && (interrupt_request_level_q != 3'h0) &&
    (iack_level_i == interrupt_request_level_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_lines_o <= 8'h00;
      iack_resp_o <= 1'b0;
      iack_vector_o <= 8'h00;
    end else begin
      irq_lines_o <= (irq_any && interrupt_request_level_q != 3'h0) ?
        8'(8'h01 << interrupt_request_level_q) : 8'h00;
      iack_resp_o <= iack_hit;
      if (iack_hit) begin
        if (!vec_init_q) begin
          iack_vector_o <= `CMC_VEC_UNINIT;
        end else if (src_boff) begin
          iack_vector_o <= {interrupt_vector_base_q, `CMC_SRC_BOFF};
        end else if (src_err) begin
          iack_vector_o <= {interrupt_vector_base_q, `CMC_SRC_ERR};
        end else begin
          iack_vector_o <= {interrupt_vector_base_q, `CMC_SRC_WAKE};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_dominant_o <= 2'b00;
      rx_prev_q <= 1'b0;
    end else begin
      rx_dominant_o <= ~(rx_level ^ receive_polarity_select_q);
      rx_prev_q <= rx_dominant_o[0];
    end
  end

  assign rx_edge = rx_dominant_o[0] && !rx_prev_q;
  assign tx_dom = core_tx_dominant_i && (mode_q == CMC_RUN);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      transmit_pin_first_o <= 1'b1;
      transmit_pin_second_o <= 1'b0;
      transmit_pin_first_oe <= 1'b1;
      transmit_pin_second_oe <= 1'b1;
    end else if (transmit_drive_select_q[1]) begin
      transmit_pin_first_o <= 1'b0;
      transmit_pin_second_o <= 1'b1;
      transmit_pin_first_oe <= tx_dom;
      transmit_pin_second_oe <= tx_dom;
    end else begin
      transmit_pin_first_o <= tx_dom ^ !transmit_drive_select_q[0];
      transmit_pin_second_o <= tx_dom ^ transmit_drive_select_q[0];
      transmit_pin_first_oe <= 1'b1;
      transmit_pin_second_oe <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  localparam int SRST_MAX = 300;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wake_exit;
    !stop_q ##1 (mode_q == CMC_RUN);
  endsequence

  property p_soft_done;
    soft_start |=> soft_reset_request ##[1:SRST_MAX] !soft_reset_request;
  endproperty
  a_soft_done: assert property (p_soft_done) else $error("soft reset stuck");

  property p_soft_stop;
    soft_start |=> !stop_q && halt_q && !wake_pend_q;
  endproperty
  a_soft_stop: assert property (p_soft_stop) else $error("soft reset state wrong");

  property p_soft_keep;
    soft_start && !wr_ctrl |=> $stable(transmit_drive_select_q) && $stable(bus_off_interrupt_mask_q);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("control zero lost");

  property p_self_wake_enable;
    wake_hit |=> s_wake_exit;
  endproperty
  a_self_wake_enable: assert property (p_self_wake_enable) else $error("self wake failed");

  property p_coincide;
    wr_modcfg && !soft_start && hwdata[`CMC_MC_SELF_WAKE_ENABLE] && rx_edge |=> !self_wake_enable_q && !stop_q;
  endproperty
  a_coincide: assert property (p_coincide) else $error("self wake set on edge");

  property p_stop_acknowledge;
    (mode_q == CMC_RUN) && stop_q |=> stop_acknowledge && not_ready_flag && !module_clk_en_o;
  endproperty
  a_stop_acknowledge: assert property (p_stop_acknowledge) else $error("stop entry wrong");

  property p_freeze_acknowledge;
    (mode_q == CMC_RUN) && freeze_want && !stop_q && !soft_start |=>
      freeze_acknowledge && !prescaler_enable_o && not_ready_flag;
  endproperty
  a_freeze_acknowledge: assert property (p_freeze_acknowledge) else $error("freeze ack with prescaler");

  property p_user;
    ap_wr_q && !ap_priv_q && supervisor_space_select_q |=> $stable(error_interrupt_mask_q);
  endproperty
  a_user: assert property (p_user) else $error("user write accepted");

  property p_boff_irq;
    src_boff && (interrupt_request_level_q == 3'h3) && !wr_intcfg && !soft_start |=>
      irq_lines_o == 8'h08;
  endproperty
  a_boff_irq: assert property (p_boff_irq) else $error("bus off request missing");

  property p_masked;
    !src_boff && !src_err && !src_wake |=> irq_lines_o == 8'h00;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request raised");

  property p_uninit;
    iack_hit && !vec_init_q |=> iack_resp_o && iack_vector_o == `CMC_VEC_UNINIT;
  endproperty
  a_uninit: assert property (p_uninit) else $error("uninitialized vector wrong");

  property p_opendrain;
    transmit_drive_select_q[1] && !tx_dom && !wr_ctrl |=> !transmit_pin_first_oe;
  endproperty
  a_opendrain: assert property (p_opendrain) else $error("open drain drives recessive");

endmodule : cmc_top
`default_nettype wire

// *** include/cmc_defines.svh ***
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH

// Register byte offsets
`define CMC_OFS_MODCFG 5'h00
`define CMC_OFS_TESTCFG 5'h04
`define CMC_OFS_INTCFG 5'h08
`define CMC_OFS_CTRLZERO 5'h0C
`define CMC_OFS_STATUS 5'h10

// Module configuration fields
`define CMC_MC_STOP 15
`define CMC_MC_FRZEN 14
`define CMC_MC_HALT 12
`define CMC_MC_NOT_READY_FLAG 11
`define CMC_MC_WAKEMASK 10
`define CMC_MC_SOFTRESET 9
`define CMC_MC_FREEZE_ACKNOWLEDGE 8
`define CMC_MC_SUPER 7
`define CMC_MC_SELF_WAKE_ENABLE 6
`define CMC_MC_AUTOPS 5
`define CMC_MC_STOP_ACKNOWLEDGE 4
`define CMC_MC_ARB_HI 3

// Interrupt configuration fields
`define CMC_IC_LVL_HI 10
`define CMC_IC_LVL_LO 8
`define CMC_IC_VEC_HI 7
`define CMC_IC_VEC_LO 5

// Control zero fields
`define CMC_C0_BOFFMASK 7
`define CMC_C0_ERRMASK 6
`define CMC_C0_RX_HI 3
`define CMC_C0_RX_LO 2
`define CMC_C0_TX_HI 1
`define CMC_C0_TX_LO 0

// Status fields
`define CMC_ST_WAKE 0
`define CMC_ST_BOFF 1
`define CMC_ST_ERR 2

// Reset values
`define CMC_RST_FRZEN 1'b1
`define CMC_RST_HALT 1'b1
`define CMC_RST_SUPER 1'b1
`define CMC_RST_LVL 3'h0
`define CMC_RST_VEC 3'h0
`define CMC_RST_ARB 4'h0
`define CMC_RST_CTRLZERO 8'h00

// Vector codes
`define CMC_VEC_UNINIT 8'h0F
`define CMC_SRC_BOFF 5'h00
`define CMC_SRC_ERR 5'h01
`define CMC_SRC_WAKE 5'h02

// Soft reset cycle length in clocks
`define CMC_SOFT_RESET_CYCLES 4

`endif

// *** include/cmc_pkg.sv ***
package cmc_pkg;

  typedef enum logic [2:0] {
    CMC_RUN = 3'b001,
    CMC_FREEZE = 3'b010,
    CMC_STOP = 3'b100
  } cmc_mode_t;

  typedef logic [1:0] cmc_transmit_drive_select_t;

endpackage : cmc_pkg

// *** tb/can_module_config_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module can_module_config_control_test;
  import cmc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [3:0] hprot = 4'h3;
  logic freeze_i = 1'b0, core_idle_i = 1'b0, bus_off_i = 1'b0, error_i = 1'b0;
  logic tx_dom = 1'b0, iack_i = 1'b0, other_dom = 1'b0;
  logic [2:0] iack_lvl = 3'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rx1, rx2, tx1, tx1oe, tx2, tx2oe, presc, clk_en, srst, iresp;
  logic [1:0] rx_dom, m, pol;
  logic [7:0] irq, ivec;
  logic [3:0] arb, e;
  cmc_mode_t mode;
  logic dd;
  int error_cnt = 0;
  int check_count = 0;
  always #2.5 hclk = ~hclk;
  cmc_top cmc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hprot(hprot), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .freeze_i(freeze_i), .core_idle_i(core_idle_i), .bus_off_i(bus_off_i), .error_i(error_i),
    .core_tx_dominant_i(tx_dom), .iack_i(iack_i), .iack_level_i(iack_lvl),
    .receive_pin_first(rx1), .receive_pin_second(rx2), .transmit_pin_first_o(tx1),
    .transmit_pin_first_oe(tx1oe), .transmit_pin_second_o(tx2), .transmit_pin_second_oe(tx2oe),
    .rx_dominant_o(rx_dom), .mode_o(mode), .prescaler_enable_o(presc),
    .module_clk_en_o(clk_en), .core_soft_reset_o(srst), .irq_lines_o(irq),
    .interrupt_arbitration_id_o(arb), .iack_resp_o(iresp), .iack_vector_o(ivec));
  cmc_xcvr cmc_xcvr_i (.tx_o(tx1), .tx_oe(tx1oe), .other_dom(other_dom), .rx_first(rx1),
    .rx_second(rx2));
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      if (n == 100) begin
        error_cnt++;
        give_verdict;
      end
      n++;
      @(posedge hclk);
    end
  endtask : wait_rdy
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic sup,
      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hprot <= {2'b00, sup, 1'b1};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask : bus
  task wr(input logic [31:0] a, input logic [31:0] d, input logic sup);
    logic [31:0] r;
    bus(1'b1, a, d, sup, r);
  endtask : wr
  task rd(input logic [31:0] a, input logic [31:0] exp, input logic sup);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, sup, r);
    chk(r, exp);
  endtask : rd
  task cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : cyc
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    chk(32'(mode), 32'(CMC_FREEZE));
    chk({31'd0, presc}, 32'h0000_0000);
    rd(32'h0000_0000, 32'h0000_5980, 1'b1);
    rd(32'h0000_0000, 32'h0000_0000, 1'b0);
    chk({31'd0, hresp}, 32'h0000_0000);
    rd(32'h0000_0018, 32'h0000_0000, 1'b1);
    wr(32'h0000_0000, 32'h0000_4990, 1'b1);
    cyc(3);
    rd(32'h0000_0000, 32'h0000_4080, 1'b1);
    chk(32'(mode), 32'(CMC_RUN));
    freeze_i <= 1'b1;
    cyc(3);
    rd(32'h0000_0000, 32'h0000_4980, 1'b1);
    freeze_i <= 1'b0;
    cyc(3);
    rd(32'h0000_0000, 32'h0000_4080, 1'b1);
    chk({31'd0, presc}, 32'h0000_0001);
    // Interrupt level 3, vector base 5, bus-off mask only
    wr(32'h0000_0008, 32'h0000_03A0, 1'b1);
    wr(32'h0000_000C, 32'h0000_0080, 1'b1);
    error_i <= 1'b1;
    cyc(3);
    chk({24'd0, irq}, 32'h0000_0000);
    bus_off_i <= 1'b1;
    cyc(3);
    chk({24'd0, irq}, 32'h0000_0008);
    iack_lvl <= 3'h2;
    iack_i <= 1'b1;
    cyc(1);
    iack_i <= 1'b0;
    chk({31'd0, iresp}, 32'h0000_0000);
    iack_lvl <= 3'h3;
    iack_i <= 1'b1;
    cyc(1);
    iack_i <= 1'b0;
    chk({23'd0, iresp, ivec}, 32'h0000_01A0);
    cyc(1);
    chk({31'd0, iresp}, 32'h0000_0000);
    bus_off_i <= 1'b0;
    cyc(3);
    chk({24'd0, irq}, 32'h0000_0000);
    error_i <= 1'b0;
    // Every transmit mode, both levels
    for (int i = 0; i < 8; i++) begin
      m = 2'(i >> 1);
      dd = i[0];
      wr(32'h0000_000C, {30'd0, m}, 1'b1);
      tx_dom <= dd;
      cyc(3);
      e = m[1] ? {1'b0, dd, 1'b1, dd} : {~dd ^ m[0], 1'b1, dd ^ m[0], 1'b1};
      chk({28'd0, tx1, tx1oe, tx2, tx2oe}, {28'd0, e});
    end
    tx_dom <= 1'b0;
    // Every receive polarity setting
    for (int i = 0; i < 4; i++) begin
      pol = 2'(i);
      other_dom <= pol[1];
      wr(32'h0000_000C, {28'd0, pol, 2'b00}, 1'b1);
      cyc(8);
      chk({30'd0, rx_dom}, {30'd0, pol[1] ? rx2 : ~rx2, pol[0] ? rx1 : ~rx1});
    end
    other_dom <= 1'b0;
    rd(32'h0000_000C, 32'h0000_0000, 1'b0);
    wr(32'h0000_000C, 32'h0000_0000, 1'b0);
    wr(32'h0000_0000, 32'h0000_4000, 1'b1);
    rd(32'h0000_000C, 32'h0000_000C, 1'b0);
    wr(32'h0000_000C, 32'h0000_00C0, 1'b1);
    // Stop with self-wake, then wake by a dominant edge
    wr(32'h0000_0000, 32'h0000_80C0, 1'b1);
    cyc(8);
    chk(32'(mode), 32'(CMC_STOP));
    chk({31'd0, clk_en}, 32'h0000_0000);
    rd(32'h0000_0000, 32'h0000_88D0, 1'b1);
    other_dom <= 1'b1;
    cyc(10);
    chk(32'(mode), 32'(CMC_RUN));
    rd(32'h0000_0000, 32'h0000_00C0, 1'b1);
    rd(32'h0000_0010, 32'h0000_0001, 1'b1);
    chk({24'd0, irq}, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0000_04C0, 1'b1);
    cyc(3);
    chk({24'd0, irq}, 32'h0000_0008);
    wr(32'h0000_0010, 32'h0000_0001, 1'b1);
    cyc(3);
    chk({24'd0, irq}, 32'h0000_0000);
    other_dom <= 1'b0;
    // Auto power save follows core idle
    wr(32'h0000_0000, 32'h0000_00A5, 1'b1);
    core_idle_i <= 1'b1;
    cyc(3);
    chk({31'd0, clk_en}, 32'h0000_0000);
    core_idle_i <= 1'b0;
    cyc(3);
    chk({31'd0, clk_en}, 32'h0000_0001);
    chk({28'd0, arb}, 32'h0000_0005);
    // Soft reset together with a stop request
    wr(32'h0000_0000, 32'h0000_8200, 1'b1);
    cyc(0);
    chk({31'd0, srst}, 32'h0000_0001);
    cyc(6);
    chk({31'd0, srst}, 32'h0000_0000);
    rd(32'h0000_0000, 32'h0000_5980, 1'b1);
    rd(32'h0000_0008, 32'h0000_0000, 1'b1);
    rd(32'h0000_000C, 32'h0000_00C0, 1'b1);
    rd(32'h0000_0010, 32'h0000_0000, 1'b1);
    // Vector base still zero after soft reset
    wr(32'h0000_0008, 32'h0000_0300, 1'b1);
    bus_off_i <= 1'b1;
    cyc(3);
    iack_i <= 1'b1;
    cyc(1);
    iack_i <= 1'b0;
    chk({23'd0, iresp, ivec}, 32'h0000_010F);
    give_verdict;
  end
endmodule : can_module_config_control_test
`default_nettype wire

// *** tb/cmc_xcvr.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmc_xcvr (
  input wire logic tx_o,
  input wire logic tx_oe,
  input wire logic other_dom,
  output logic rx_first,
  output logic rx_second
);
  logic bus_dom;
  // Released pin is pulled to recessive; other nodes may pull dominant
  assign bus_dom = other_dom | (tx_oe & ~tx_o);
  assign rx_first = ~bus_dom;
  // Second receiver is an inverting one, so the two pins differ
  assign rx_second = bus_dom;
endmodule : cmc_xcvr
`default_nettype wire
